// [design/clk_pkg.sv]
// constants and carrier types of the switching clock manager
// assumes an apb master on the same clock and static fuse levels
package clk_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [11:0] ctrl_offset = 12'h000;
   localparam logic [11:0] status_offset = 12'h004;
   localparam logic [11:0] flags_offset = 12'h008;
   localparam logic [11:0] mask_offset = 12'h00c;

   // ****************************************
   // timing
   // ****************************************
   localparam int clock_khz = 200000;
   localparam int clock_period_ns = 5;
   localparam int step_dwell_ns = 5200;
   localparam int step_dwell_cycles = (step_dwell_ns + clock_period_ns - 1) / clock_period_ns;
   localparam int spread_mod_khz = 24;
   localparam int spread_period_cycles = clock_khz / spread_mod_khz;
   localparam int band_fast_min_khz = 2000;
   localparam int band_fast_max_khz = 3000;
   localparam int band_slow_min_khz = 333;
   localparam int band_slow_max_khz = 500;
   localparam logic [10:0] fast_min_cycles = 11'((clock_khz + band_fast_max_khz - 1) / band_fast_max_khz);
   localparam logic [10:0] fast_max_cycles = 11'(clock_khz / band_fast_min_khz);
   localparam logic [10:0] slow_min_cycles = 11'((clock_khz + band_slow_max_khz - 1) / band_slow_max_khz);
   localparam logic [10:0] slow_max_cycles = 11'(clock_khz / band_slow_min_khz);
   localparam logic [10:0] period_saturate = 11'h7ff;

   // ****************************************
   // trim encoding and spread widths
   // ****************************************
   localparam logic [3:0] trim_top_code = 4'h4;
   localparam logic [3:0] trim_low_base_code = 4'h9;
   localparam logic [3:0] trim_low_top_code = 4'hc;
   localparam logic [3:0] trim_nominal_index = 4'h4;
   localparam logic [3:0] trim_nominal_code = 4'h0;
   localparam logic signed [4:0] spread_narrow_pct = 5'sh05;
   localparam logic signed [4:0] spread_wide_pct = 5'sh0a;
   localparam int flag_trim_done = 0;
   localparam int flag_ext_fault = 1;

   typedef struct packed {
      logic clock_repeat_enable;
      logic ext_clock_band_sel;
      logic ext_clock_allow;
      logic spread_width_sel;
      logic spread_enable;
      logic [3:0] hf_clock_trim;
   } ctrl_t;

   localparam ctrl_t ctrl_reset = '0;
   localparam int ctrl_bits = $bits(ctrl_t);

   typedef struct packed {
      logic ramping;
      logic ext_fault_live;
      logic ext_selected;
      logic pll_on;
      logic spread_active;
      logic [3:0] applied_code;
   } status_t;

endpackage

// [design/switching_clock_manager.sv]
// clock selection, trim ramp, spread and sync control of the buck clocks
// assumes an apb master on clock; fuses, hf and ext clocks arrive as pins
// What this block does
// - all control logic and timers on one clock
// - trim codes map to 16 to 24 MHz
// - multi-step change ramps with dwell per step
// - reaching target sets flag, drives interrupt unmasked
// - internal switching clock is hf divided by eight
// - trim loaded from fuse bits at start
// - manual trim ignored under spread or sync
// - spread enable bit turns spreading on, off
// - width bit selects five or ten percent
// - spread, band, repeat bits start from fuses
// - spread modulates at fixed rate when internal
// - external sync enabled forces spread off
// - fuse zero keeps pll off, internal clock
// - fuse one keeps pll on, either source
// - sync input valid only inside chosen band
// - bad sync falls back internal, sets fault flag
// - live fault bit follows sync input validity
// - return external only after clear and valid
// - repeat output toggles when enabled, else low
module switching_clock_manager #(
   parameter int STEP_DWELL_CYCLES = clk_pkg::step_dwell_cycles,
   parameter int SPREAD_PERIOD_CYCLES = clk_pkg::spread_period_cycles
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hf_clock_in,
   input wire logic ext_clock_in,
   input wire logic system_on,
   input wire clk_pkg::ctrl_t fuses,
   output logic irq_out_n,
   output logic [3:0] hf_step_code,
   output logic signed [4:0] spread_offset,
   output logic pll_enable,
   output logic pll_source_ext,
   output logic sw_clock_out,
   output logic clock_repeat_out
);

   localparam int dw = $clog2(STEP_DWELL_CYCLES + 1);
   localparam int sw = $clog2(SPREAD_PERIOD_CYCLES + 1);
   localparam int in_w = clk_pkg::ctrl_bits + 3;

   if (STEP_DWELL_CYCLES < 1 || SPREAD_PERIOD_CYCLES < 40) begin : g_check
      $error("dwell or spread period too short");
   end

   // ****************************************
   // decoding helpers
   // ****************************************
   function automatic logic trim_valid(input logic [3:0] code);
      trim_valid = (code <= clk_pkg::trim_top_code) ||
         (code >= clk_pkg::trim_low_base_code && code <= clk_pkg::trim_low_top_code);
   endfunction

   function automatic logic [3:0] code_to_index(input logic [3:0] code);
      if (code <= clk_pkg::trim_top_code) begin
         code_to_index = code + clk_pkg::trim_nominal_index;
      end else begin
         code_to_index = code - clk_pkg::trim_low_base_code;
      end
   endfunction

   function automatic logic [3:0] index_to_code(input logic [3:0] idx);
      if (idx >= clk_pkg::trim_nominal_index) begin
         index_to_code = idx - clk_pkg::trim_nominal_index;
      end else begin
         index_to_code = idx + clk_pkg::trim_low_base_code;
      end
   endfunction

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
      hit = (addr == offset);
   endfunction

   // ****************************************
   // pin synchronisers and fuse load
   // ****************************************
   logic [in_w-1:0] sync1;
   logic [in_w-1:0] sync2;
   logic [1:0] load_count;
   logic fuse_load;
   logic loaded;
   clk_pkg::ctrl_t fuse_s;
   logic hf_s;
   logic ext_s;
   logic on_s;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {system_on, ext_clock_in, hf_clock_in, fuses};
         sync2 <= sync1;
      end
   end

   assign fuse_s = clk_pkg::ctrl_t'(sync2[clk_pkg::ctrl_bits-1:0]);
   assign hf_s = sync2[in_w-3];
   assign ext_s = sync2[in_w-2];
   assign on_s = sync2[in_w-1];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         load_count <= 2'h0;
      end else if (load_count != 2'h3) begin
         load_count <= load_count + 2'h1;
      end
   end

   assign fuse_load = (load_count == 2'h2);
   assign loaded = (load_count == 2'h3);

   // ****************************************
   // apb slave
   // ****************************************
   clk_pkg::ctrl_t ctrl;
   clk_pkg::status_t status;
   logic [1:0] flags;
   logic [1:0] mask;
   logic fuse_allow;
   logic access;
   logic take;
   logic mapped;
   logic wr_ctrl;
   logic wr_flags;
   logic wr_mask;
   logic [31:0] next_prdata;

   assign access = psel && penable;
   assign take = access && pready;
   assign mapped = hit(paddr, clk_pkg::ctrl_offset) || hit(paddr, clk_pkg::status_offset) ||
      hit(paddr, clk_pkg::flags_offset) || hit(paddr, clk_pkg::mask_offset);
   assign wr_ctrl = take && pwrite && hit(paddr, clk_pkg::ctrl_offset);
   assign wr_flags = take && pwrite && hit(paddr, clk_pkg::flags_offset);
   assign wr_mask = take && pwrite && hit(paddr, clk_pkg::mask_offset);

   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit(paddr, clk_pkg::ctrl_offset)) begin
         next_prdata[clk_pkg::ctrl_bits-1:0] = ctrl;
      end else if (hit(paddr, clk_pkg::status_offset)) begin
         next_prdata[$bits(clk_pkg::status_t)-1:0] = status;
      end else if (hit(paddr, clk_pkg::flags_offset)) begin
         next_prdata[1:0] = flags;
      end else if (hit(paddr, clk_pkg::mask_offset)) begin
         next_prdata[1:0] = mask;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access && !pready && loaded;
         pslverr <= access && !pready && loaded && !mapped;
         if (access && !pready && loaded && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl <= clk_pkg::ctrl_reset;
         fuse_allow <= 1'b0;
      end else if (fuse_load) begin
         ctrl <= fuse_s;
         fuse_allow <= fuse_s.ext_clock_allow;
      end else if (wr_ctrl) begin
         ctrl <= clk_pkg::ctrl_t'(pwdata[clk_pkg::ctrl_bits-1:0]);
         if (!on_s) begin
            ctrl.clock_repeat_enable <= ctrl.clock_repeat_enable;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask <= 2'h0;
      end else if (wr_mask) begin
         mask <= pwdata[1:0];
      end
   end

   // ****************************************
   // trim target and stepped ramp
   // ****************************************
   logic [3:0] target_index;
   logic [3:0] applied_index;
   logic [3:0] eff_index;
   logic [dw-1:0] dwell;
   logic ramp_done;
   logic ext_enabled;
   logic spread_active;
   logic ext_selected;
   logic fault_live;

   assign ext_enabled = fuse_allow && ctrl.ext_clock_allow;
   assign spread_active = ctrl.spread_enable && !ext_enabled;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         target_index <= clk_pkg::trim_nominal_index;
      end else if (fuse_load && trim_valid(fuse_s.hf_clock_trim)) begin
         target_index <= code_to_index(fuse_s.hf_clock_trim);
      end else if (wr_ctrl && trim_valid(pwdata[3:0])) begin
         target_index <= code_to_index(pwdata[3:0]);
      end
   end

   always_comb begin
      if (spread_active) begin
         eff_index = clk_pkg::trim_nominal_index;
      end else if (ext_selected) begin
         eff_index = applied_index;
      end else begin
         eff_index = target_index;
      end
   end

   assign ramp_done = loaded && dwell == '0 && applied_index != eff_index &&
      (applied_index < eff_index ? applied_index + 4'h1 : applied_index - 4'h1) == eff_index;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         applied_index <= clk_pkg::trim_nominal_index;
         dwell <= '0;
      end else if (fuse_load) begin
         if (trim_valid(fuse_s.hf_clock_trim)) begin
            applied_index <= code_to_index(fuse_s.hf_clock_trim);
         end
      end else if (dwell != '0) begin
         dwell <= dwell - 1'b1;
      end else if (applied_index != eff_index) begin
         if (applied_index < eff_index) begin
            applied_index <= applied_index + 4'h1;
         end else begin
            applied_index <= applied_index - 4'h1;
         end
         dwell <= dw'(STEP_DWELL_CYCLES - 1);
      end
   end

   // ****************************************
   // spread modulation triangle
   // ****************************************
   logic [sw-1:0] ss_count;
   logic [sw-1:0] ss_interval;
   logic signed [4:0] ss_width;
   logic ss_up;

   assign ss_width = ctrl.spread_width_sel ? clk_pkg::spread_wide_pct : clk_pkg::spread_narrow_pct;
   assign ss_interval = ctrl.spread_width_sel ? sw'(SPREAD_PERIOD_CYCLES / 40) : sw'(SPREAD_PERIOD_CYCLES / 20);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ss_count <= '0;
         ss_up <= 1'b1;
         spread_offset <= 5'sh00;
      end else if (!spread_active || ext_selected) begin
         ss_count <= '0;
         ss_up <= 1'b1;
         spread_offset <= 5'sh00;
      end else if (ss_count < ss_interval - 1'b1) begin
         ss_count <= ss_count + 1'b1;
      end else begin
         ss_count <= '0;
         if (ss_up) begin
            if (spread_offset >= ss_width) begin
               ss_up <= 1'b0;
               spread_offset <= spread_offset - 5'sh01;
            end else begin
               spread_offset <= spread_offset + 5'sh01;
            end
         end else begin
            if (spread_offset <= -ss_width) begin
               ss_up <= 1'b1;
               spread_offset <= spread_offset + 5'sh01;
            end else begin
               spread_offset <= spread_offset - 5'sh01;
            end
         end
      end
   end

   // ****************************************
   // external clock measurement and selection
   // ****************************************
   logic ext_d;
   logic ext_edge;
   logic [10:0] period;
   logic [10:0] band_min;
   logic [10:0] band_max;

   assign ext_edge = ext_s && !ext_d;
   assign band_min = ctrl.ext_clock_band_sel ? clk_pkg::slow_min_cycles : clk_pkg::fast_min_cycles;
   assign band_max = ctrl.ext_clock_band_sel ? clk_pkg::slow_max_cycles : clk_pkg::fast_max_cycles;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_d <= 1'b0;
         period <= 11'h000;
         fault_live <= 1'b1;
      end else begin
         ext_d <= ext_s;
         if (ext_edge) begin
            period <= 11'h001;
            fault_live <= !(period >= band_min && period <= band_max);
         end else begin
            if (period != clk_pkg::period_saturate) begin
               period <= period + 11'h001;
            end
            if (period > band_max) begin
               fault_live <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_selected <= 1'b0;
      end else begin
         ext_selected <= ext_enabled && !fault_live && !flags[clk_pkg::flag_ext_fault];
      end
   end

   // ****************************************
   // interrupt flags
   // ****************************************
   logic [1:0] flag_set;
   logic [1:0] flag_clear;

   assign flag_set = {ext_enabled && fault_live, ramp_done};
   assign flag_clear = wr_flags ? pwdata[1:0] : 2'h0;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flags <= 2'h0;
         irq_out_n <= 1'b1;
      end else begin
         flags <= (flags & ~flag_clear) | flag_set;
         irq_out_n <= !(|(flags & ~mask));
      end
   end

   // ****************************************
   // switching clock divider and outputs
   // ****************************************
   logic hf_d;
   logic [1:0] div;
   logic int_sw;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hf_d <= 1'b0;
         div <= 2'h0;
         int_sw <= 1'b0;
      end else begin
         hf_d <= hf_s;
         if (hf_s && !hf_d) begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
               int_sw <= !int_sw;
            end
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sw_clock_out <= 1'b0;
         clock_repeat_out <= 1'b0;
         pll_enable <= 1'b0;
         pll_source_ext <= 1'b0;
         hf_step_code <= clk_pkg::trim_nominal_code;
      end else begin
         sw_clock_out <= ext_selected ? ext_d : int_sw;
         clock_repeat_out <= ctrl.clock_repeat_enable && (ext_selected ? ext_d : int_sw);
         pll_enable <= fuse_allow;
         pll_source_ext <= fuse_allow && ext_selected;
         hf_step_code <= index_to_code(applied_index);
      end
   end

   assign status = '{ramping: applied_index != eff_index, ext_fault_live: fault_live,
      ext_selected: ext_selected, pll_on: pll_enable, spread_active: spread_active,
      applied_code: hf_step_code};

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   irq_trim_a: assert property (flags[0] && !mask[0] |=> !irq_out_n) else $error("irq not raised");
   done_flag_a: assert property (ramp_done |=> flags[0]) else $error("done flag missing");
   step_size_a: assert property ($changed(applied_index) && !$past(fuse_load) |->
      (applied_index == $past(applied_index) + 4'h1 || applied_index == $past(applied_index) - 4'h1))
      else $error("step larger than one");
   step_dwell_a: assert property ($changed(applied_index) && !$past(fuse_load) |->
      dwell == dw'(STEP_DWELL_CYCLES - 1)) else $error("dwell not loaded");
   bad_trim_a: assert property (wr_ctrl && !trim_valid(pwdata[3:0]) && !fuse_load |=> $stable(target_index))
      else $error("unused code moved target");
   spread_off_a: assert property (ext_enabled && $past(ext_enabled) |-> spread_offset == 5'sh00)
      else $error("spread while synced");
   narrow_band_a: assert property (!ctrl.spread_width_sel && spread_offset <= 5'sh05 && spread_offset >= -5'sh05
      |=> spread_offset <= 5'sh05 && spread_offset >= -5'sh05) else $error("narrow spread exceeded");
   pll_fuse_a: assert property (!fuse_allow |=> !pll_enable && !pll_source_ext) else $error("pll on");
   fault_flag_a: assert property (ext_enabled && fault_live |=> flags[1]) else $error("fault flag missing");
   return_ext_a: assert property ($rose(ext_selected) |-> !$past(flags[1]) && !$past(fault_live))
      else $error("early return to external");
   timeout_a: assert property (!ext_edge && period > band_max |=> fault_live) else $error("missing clock");
   repeat_low_a: assert property (!ctrl.clock_repeat_enable |=> !clock_repeat_out) else $error("repeat on");
   divide_a: assert property ($changed(int_sw) |-> $past(hf_s && !hf_d && div == 2'h3))
      else $error("divider slip");

   ramp_done_c: cover property (ramp_done && dwell == '0 ##1 flags[0]);
   ext_back_c: cover property ($fell(flags[1]) ##[1:20] $rose(ext_selected));
   spread_peak_c: cover property (spread_active && spread_offset == ss_width);

endmodule

// [tb/ext_clock_source.sv]
// far side of the sync input: an external clock source driving the sync pin
// assumes the bench clock as time base; pin has a pull-down when the source is off
module ext_clock_source (
   input wire logic clock,
   input wire logic on,
   input wire logic [7:0] half,
   output logic ext_clock_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // source clock generation
   // ****************************************
   logic [7:0] cnt = 8'h00;
   logic pin = 1'b0;
   assign ext_clock_in = pin;
   always @(posedge clock) begin
      if (!on) begin
         cnt <= 8'h00;
         pin <= 1'b0;
      end else if (cnt + 8'h01 >= half) begin
         cnt <= 8'h00;
         pin <= ~pin;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// [tb/test_switching_clock_manager.sv]
// self-checking bench of the switching clock manager
// assumes clk_pkg and the external clock source model are compiled first
module test_switching_clock_manager;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // signals
   // ****************************************
   localparam int DW = 4;
   localparam int SP = 80;
   logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic system_on = 1'b1, hf_clock_in = 1'b0, ext_on = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, lfsr_state = 32'h9e43;
   logic pready, pslverr, irq_out_n, pll_enable, pll_source_ext, sw_clock_out, clock_repeat_out, ext_clock_in;
   logic [3:0] hf_step_code, last_code = 4'h0;
   logic signed [4:0] spread_offset;
   logic [7:0] ext_half = 8'h28;
   clk_pkg::ctrl_t fuses = clk_pkg::ctrl_t'(9'h142);
   logic [33:0] rd_q[$];
   logic [3:0] code_q[$];
   int err_total = 0, cmp_count = 0, cyc = 0, last_cyc = 0;
   int hf_r, sw_r, rep_r, smax, smin;
   always #2.5 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   always begin
      repeat (5) @(posedge clock);
      hf_clock_in <= ~hf_clock_in;
   end
   switching_clock_manager #(.STEP_DWELL_CYCLES(DW), .SPREAD_PERIOD_CYCLES(SP)) dut_u (.clock(clock), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hf_clock_in(hf_clock_in), .ext_clock_in(ext_clock_in),
      .system_on(system_on), .fuses(fuses), .irq_out_n(irq_out_n), .hf_step_code(hf_step_code),
      .spread_offset(spread_offset), .pll_enable(pll_enable), .pll_source_ext(pll_source_ext),
      .sw_clock_out(sw_clock_out), .clock_repeat_out(clock_repeat_out));
   ext_clock_source src_u (.clock(clock), .on(ext_on), .half(ext_half), .ext_clock_in(ext_clock_in));
   // ****************************************
   // tasks
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task end_sim;
      if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
      int n;
      rd_q.push_back({!w, er, e});
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) begin
         err_total++;
         end_sim;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic er);
      apb(1'b0, a, 32'h0, e, er);
   endtask
   task wait_code(input logic [3:0] c);
      int n;
      n = 0;
      while (hf_step_code !== c && n < 500) begin
         @(negedge clock);
         n++;
      end
      if (n >= 500) begin
         err_total++;
         end_sim;
      end
   endtask
   task measure(input int n);
      logic ph, ps, pr;
      hf_r = 0;
      sw_r = 0;
      rep_r = 0;
      smax = -99;
      smin = 99;
      ph = hf_clock_in;
      ps = sw_clock_out;
      pr = clock_repeat_out;
      repeat (n) begin
         @(negedge clock);
         hf_r += int'(hf_clock_in & !ph);
         sw_r += int'(sw_clock_out & !ps);
         rep_r += int'(clock_repeat_out & !pr);
         if (spread_offset > smax) smax = spread_offset;
         if (spread_offset < smin) smin = spread_offset;
         ph = hf_clock_in;
         ps = sw_clock_out;
         pr = clock_repeat_out;
      end
   endtask
   // ****************************************
   // monitor
   // ****************************************
   always @(posedge clock) begin
      logic [33:0] t;
      if (pready === 1'b1) begin
         t = rd_q.pop_front();
         chk("pslverr", {31'h0, t[32]}, {31'h0, pslverr});
         if (t[33]) chk("prdata", t[31:0], prdata);
      end
      if (!rst && hf_step_code !== last_code) begin
         chk("step code", {28'h0, code_q.pop_front()}, {28'h0, hf_step_code});
         if (last_cyc != 0) chk("dwell", 32'h1, {31'h0, cyc - last_cyc >= DW});
         last_code = hf_step_code;
         last_cyc = cyc;
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      code_q.push_back(4'h2);
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      rd(clk_pkg::ctrl_offset, 32'h142, 1'b0);
      wr(clk_pkg::mask_offset, 32'h2);
      chk("pll_enable", 32'h1, {31'h0, pll_enable});
      measure(800);
      chk("sw rate", 32'h1, {31'h0, sw_r >= 9 && sw_r <= 11 && hf_r >= 79});
      chk("repeat rate", 32'h1, {31'h0, rep_r + 1 >= sw_r && rep_r <= sw_r + 1});
      code_q = {4'h1, 4'h0, 4'hc, 4'hb, 4'ha, 4'h9};
      wr(clk_pkg::ctrl_offset, 32'h149);
      wait_code(4'h9);
      repeat (3) @(negedge clock);
      chk("irq_out_n", 32'h0, {31'h0, irq_out_n});
      wr(clk_pkg::ctrl_offset, 32'h146);
      rd(clk_pkg::status_offset, 32'ha9, 1'b0);
      rd(clk_pkg::ctrl_offset, 32'h146, 1'b0);
      rd(12'h010, 32'h0, 1'b1);
      wr(clk_pkg::flags_offset, 32'h1);
      repeat (3) @(negedge clock);
      chk("irq_out_n", 32'h1, {31'h0, irq_out_n});
      @(posedge clock);
      system_on <= 1'b0;
      repeat (4) @(posedge clock);
      wr(clk_pkg::ctrl_offset, 32'h046);
      rd(clk_pkg::ctrl_offset, 32'h146, 1'b0);
      system_on <= 1'b1;
      repeat (4) @(posedge clock);
      wr(clk_pkg::ctrl_offset, 32'h046);
      repeat (2) @(posedge clock);
      measure(400);
      chk("repeat off", 32'h0, rep_r + int'(clock_repeat_out));
      code_q = {4'ha, 4'hb, 4'hc, 4'h0};
      wr(clk_pkg::ctrl_offset, 32'h019);
      wait_code(4'h0);
      measure(2 * SP);
      chk("spread max", 32'h5, smax);
      chk("spread min", -32'sh5, smin);
      wr(clk_pkg::ctrl_offset, 32'h039);
      measure(2 * SP);
      chk("spread max", 32'ha, smax);
      chk("spread min", -32'sha, smin);
      wr(clk_pkg::ctrl_offset, 32'h070);
      repeat (2) @(posedge clock);
      measure(2 * SP);
      chk("spread off", 32'h0, smax | smin);
      lfsr_state = lfsr(lfsr_state);
      @(posedge clock);
      ext_half <= 8'h23 + 8'(lfsr_state % 14);
      ext_on <= 1'b1;
      repeat (600) @(posedge clock);
      rd(clk_pkg::status_offset, 32'h020, 1'b0);
      wr(clk_pkg::flags_offset, 32'h2);
      rd(clk_pkg::status_offset, 32'h060, 1'b0);
      chk("pll ext", 32'h1, {31'h0, pll_source_ext});
      wr(clk_pkg::ctrl_offset, 32'h064);
      rd(clk_pkg::status_offset, 32'h060, 1'b0);
      code_q = {4'h1, 4'h2, 4'h3, 4'h4};
      ext_on <= 1'b0;
      wait_code(4'h4);
      chk("pll ext", 32'h0, {31'h0, pll_source_ext});
      rd(clk_pkg::flags_offset, 32'h3, 1'b0);
      repeat (2) @(posedge clock);
      if (rd_q.size() != 0 || code_q.size() != 0) begin
         err_total++;
         $display("BAD queue expected 0 seen %0d", rd_q.size() + code_q.size());
      end
      end_sim;
   end
endmodule
